// ===== hw/amx_acc.sv
// Four 64-bit accumulators with multiply-subtract, half moves and shift-in.
// Assumes the pipeline holds a request until op_ready, and a read until rd_valid.
//
// Behaviour
// RULE1 - Signed multiply-subtract: sign-extend both words, subtract signed product.
// RULE2 - Unsigned multiply-subtract: zero-extend both words, subtract unsigned product.
// RULE3 - Full 64-bit difference written back: bits 63..32 upper, 31..0 bottom.
// RULE4 - Multiply-subtract never raises an arithmetic fault; result wraps modulo 2^64.
// RULE5 - Pair index 0..3; index 0 is the base upper/bottom pair.
// RULE6 - Multiply-subtract updates only the selected accumulator, no general register.
// RULE7 - Any operation may end in reserved-instruction or module-disabled exception.
// RULE8 - Multiply runs in background; reads of its accumulator stall until written.
// RULE9 - Move to upper copies source into upper half, bottom untouched.
// RULE10 - Move to bottom copies source into bottom half from bit 0, upper untouched.
// RULE11 - Base product result in pair 0 must be read before either half is written; the code only raises base_unread and does not hold off such writes.
// RULE12 - Read-before-write restriction only for pair 0; pairs 1..3 always writable.
// RULE13 - Shift-in moves bottom word to upper, loads source low word into bottom.
// RULE14 - After shift-in, bit-cursor field increases by 32.
// RULE15 - Software keeps cursor at 32 or less before shift-in, else cursor undefined.
// RULE16 - Software detects multiply-subtract overflow itself; no flag or trap exists.
// RULE17 - Software should place the shorter operand in the second source.
// RULE18 - Each accumulator is 64 bits: upper bits 63..32, bottom bits 31..0.
`default_nettype none

module amx_acc #(
  parameter int unsigned MUL_LAT = amx_pkg::MUL_LAT
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // Module enable from the control state
  input  wire logic              sp_enable,
  // Operation request and answer
  input  wire logic              op_valid,
  input  wire amx_pkg::amx_req_s op_req,
  output logic                   op_ready,
  output amx_pkg::amx_rsp_s      op_rsp,
  // Accumulator read port
  input  wire amx_pkg::amx_rd_s  rd,
  output logic                   rd_valid,
  output logic [31:0]            rd_data,
  // Base product write into pair 0
  input  wire logic              base_wr,
  input  wire logic [63:0]       base_value,
  output logic                   base_unread,
  // Bit-cursor field of the control register
  input  wire logic              cursor_load,
  input  wire logic [5:0]        cursor_value,
  output logic [5:0]             cursor
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [3:0][63:0]     acc;
    logic [5:0]           cursor;
    logic                 busy;
    logic [1:0]           pend_idx;
    logic                 op_ready;
    amx_pkg::amx_rsp_s    rsp;
    logic                 rd_valid;
    logic [31:0]          rd_data;
    logic                 base_unread;
  } amx_acc_st_s;

  amx_acc_st_s st_reg;
  amx_acc_st_s st_next;

  logic        take;
  logic        is_mul;
  logic        mul_valid;
  logic [63:0] mul_product;

  function automatic logic [31:0] upper_half_word(input logic [63:0] v);
    upper_half_word = v[63:32];
  endfunction

  function automatic logic [31:0] bottom_half_word(input logic [63:0] v);
    bottom_half_word = v[31:0];
  endfunction

  assign take   = op_valid && st_reg.op_ready;
  assign is_mul = (op_req.op == amx_pkg::op_mul_sub_signed) ||
                  (op_req.op == amx_pkg::op_mul_sub_unsigned);

  // ==========================================================================
  // Multiplier
  // The pipeline keeps running while later requests wait; only a low clk_en stalls it.
  amx_mul #(
    .LAT       (MUL_LAT)
  ) u_mul (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .start     (take && is_mul && sp_enable && !op_req.reserved),
    .is_signed (op_req.op == amx_pkg::op_mul_sub_signed),        // RULE1 RULE2
    .a         (op_req.source_one),
    .b         (op_req.source_two),
    .valid     (mul_valid),
    .product   (mul_product)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    st_next              = st_reg;
    st_next.rsp          = '{done: 1'b0, exc: amx_pkg::exc_none};
    st_next.rd_valid     = 1'b0;

    // Base product lands in pair 0 and must be read back first
    if (base_wr) begin
      st_next.acc[amx_pkg::BASE_PAIR] = base_value;                 // RULE5
      st_next.base_unread             = 1'b1;                       // RULE11
    end

    if (cursor_load) begin
      st_next.cursor = cursor_value;
    end

    // Wraps silently; no overflow status exists for this path
    if (mul_valid) begin
      st_next.acc[st_reg.pend_idx] = st_reg.acc[st_reg.pend_idx] - mul_product; // RULE3 RULE4 RULE6
      st_next.busy                 = 1'b0;
      st_next.rsp.done             = 1'b1;
    end

    if (take) begin
      if (op_req.reserved) begin
        st_next.rsp = '{done: 1'b1, exc: amx_pkg::exc_reserved};     // RULE7
      end else if (!sp_enable) begin
        st_next.rsp = '{done: 1'b1, exc: amx_pkg::exc_disabled};     // RULE7
      end else begin
        unique case (op_req.op)
          amx_pkg::op_mul_sub_signed,
          amx_pkg::op_mul_sub_unsigned: begin
            st_next.busy     = 1'b1;                                  // RULE8
            st_next.pend_idx = op_req.pair_index;
          end
          amx_pkg::op_move_to_upper: begin
            st_next.acc[op_req.pair_index][63:32] = op_req.source_one; // RULE9 RULE12
            st_next.rsp.done = 1'b1;
          end
          amx_pkg::op_move_to_bottom: begin
            st_next.acc[op_req.pair_index][31:0] = op_req.source_one;  // RULE10 RULE12
            st_next.rsp.done = 1'b1;
          end
          amx_pkg::op_shift_in_word: begin
            st_next.acc[op_req.pair_index] =
              {bottom_half_word(st_reg.acc[op_req.pair_index]), op_req.source_one}; // RULE13
            // From 32 upward the sum simply wraps in the field width
            st_next.cursor   = st_next.cursor + amx_pkg::CURSOR_STEP;  // RULE14 RULE15
            st_next.rsp.done = 1'b1;
          end
          default: begin
            st_next.rsp = '{done: 1'b1, exc: amx_pkg::exc_reserved};
          end
        endcase
      end
    end

    // Read of a pair whose product is still in flight waits for the writeback
    if (rd.req && !(st_reg.busy && rd.pair_index == st_reg.pend_idx)) begin // RULE8
      st_next.rd_valid = 1'b1;
      st_next.rd_data  = rd.upper ? upper_half_word(st_reg.acc[rd.pair_index]) :
                                    bottom_half_word(st_reg.acc[rd.pair_index]); // RULE18
      if (rd.pair_index == amx_pkg::BASE_PAIR && !base_wr) begin
        st_next.base_unread = 1'b0;
      end
    end

    // One multiply in flight at a time keeps the pending tag simple
    st_next.op_ready = !st_next.busy;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg.acc         <= {amx_pkg::NUM_ACC{amx_pkg::ACC_RST}};
      st_reg.cursor      <= amx_pkg::CURSOR_RST;
      st_reg.busy        <= 1'b0;
      st_reg.pend_idx    <= 2'h0;
      st_reg.op_ready    <= 1'b1;
      st_reg.rsp         <= '{done: 1'b0, exc: amx_pkg::exc_none};
      st_reg.rd_valid    <= 1'b0;
      st_reg.rd_data     <= 32'h0000_0000;
      st_reg.base_unread <= 1'b0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign op_ready    = st_reg.op_ready;
  assign op_rsp      = st_reg.rsp;
  assign rd_valid    = st_reg.rd_valid;
  assign rd_data     = st_reg.rd_data;
  assign base_unread = st_reg.base_unread;
  assign cursor      = st_reg.cursor;

endmodule

`default_nettype wire

// ===== inc/amx_pkg.sv
// Shared widths, timing counts, operation codes and carrier structs of the
// accumulator multiply-subtract and move slice.
// Assumes the pipeline decodes instructions into amx_req_s beats on mclk.
`default_nettype none

package amx_pkg;

  // ==========================================================================
  // Widths and counts
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ACC_W       = 64;
  localparam int unsigned NUM_ACC     = 4;
  localparam int unsigned IDX_W       = 2;
  localparam int unsigned CURSOR_W    = 6;
  localparam int unsigned MUL_LAT     = 2;
  localparam logic [5:0]  CURSOR_STEP = 6'h20;
  localparam logic [5:0]  CURSOR_RST  = 6'h00;
  localparam logic [63:0] ACC_RST     = 64'h0000_0000_0000_0000;
  localparam logic [1:0]  BASE_PAIR   = 2'h0;

  // ==========================================================================
  // Operation and exception codes
  typedef enum logic [2:0] {
    op_mul_sub_signed,
    op_mul_sub_unsigned,
    op_move_to_upper,
    op_move_to_bottom,
    op_shift_in_word
  } amx_op_e;

  typedef enum logic [1:0] {
    exc_none,
    exc_reserved,
    exc_disabled
  } amx_exc_e;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    amx_op_e     op;
    logic        reserved;
    logic [1:0]  pair_index;
    logic [31:0] source_one;
    logic [31:0] source_two;
  } amx_req_s;

  typedef struct packed {
    logic     done;
    amx_exc_e exc;
  } amx_rsp_s;

  typedef struct packed {
    logic       req;
    logic [1:0] pair_index;
    logic       upper;
  } amx_rd_s;

endpackage

`default_nettype wire

// ===== hw/amx_mul.sv
// Pipelined 32x32 multiplier, signed or unsigned, for the multiply-subtract path.
// Assumes start is a single-cycle pulse from logic on mclk.
`default_nettype none

module amx_mul #(
  parameter int unsigned LAT = amx_pkg::MUL_LAT
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // Operands
  input  wire logic        start,
  input  wire logic        is_signed,
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  // Result
  output logic             valid,
  output logic [63:0]      product
);

  typedef struct packed {
    logic [LAT-1:0]        vld;
    logic [LAT-1:0][63:0]  prod;
  } amx_mul_st_s;

  amx_mul_st_s st_reg;
  amx_mul_st_s st_next;

  // Sign bit or zero above the word, so one signed multiplier serves both kinds
  function automatic logic signed [32:0] ext33(input logic s, input logic [31:0] w);
    ext33 = signed'({s & w[31], w});
  endfunction

  logic signed [65:0] full;

  always_comb begin
    full    = ext33(is_signed, a) * ext33(is_signed, b);
    st_next = st_reg;
    st_next.vld[0]  = start;
    st_next.prod[0] = full[63:0];
    for (int i = 1; i < LAT; i++) begin
      st_next.vld[i]  = st_reg.vld[i-1];
      st_next.prod[i] = st_reg.prod[i-1];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign valid   = st_reg.vld[LAT-1];
  assign product = st_reg.prod[LAT-1];

endmodule

`default_nettype wire

// ===== bench/amx_acc_monitor.sv
// Checker of the accumulator slice, bound to every amx_acc.
// Assumes clk_en stays high while requests are in flight.
`default_nettype none

module amx_acc_monitor #(
  parameter int unsigned MUL_LAT = amx_pkg::MUL_LAT
) (
  // Clock, reset and requests
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              clk_en,
  input wire logic              sp_enable,
  input wire logic              op_valid,
  input wire amx_pkg::amx_req_s op_req,
  input wire amx_pkg::amx_rd_s  rd,
  input wire logic              base_wr,
  input wire logic              cursor_load,
  // Answers
  input wire logic              op_ready,
  input wire amx_pkg::amx_rsp_s op_rsp,
  input wire logic              rd_valid,
  input wire logic              base_unread,
  input wire logic [5:0]        cursor
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Decode of taken requests
  localparam int MD = MUL_LAT + 1;
  logic take;
  logic ok;
  logic mul;
  assign take = op_valid && op_ready && clk_en;
  assign ok   = take && !op_req.reserved && sp_enable;
  assign mul  = ok && (op_req.op <= amx_pkg::op_mul_sub_unsigned);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Properties
  a_mul_answer_late: assert property (mul |-> ##MD op_rsp.done)
    else $error("multiply-subtract answer not on time");
  a_mul_no_fault: assert property (mul |-> ##MD op_rsp.exc == amx_pkg::exc_none)
    else $error("multiply-subtract raised a fault");
  a_mul_holds_off: assert property (mul |=> !op_ready)
    else $error("new request accepted during multiply");
  a_move_one_cycle: assert property (ok && !mul |=> op_rsp.done && !op_ready == 1'b0)
    else $error("move answer not one cycle later");
  a_resv_refused: assert property (take && op_req.reserved |=>
    op_rsp.done && op_rsp.exc == amx_pkg::exc_reserved)
    else $error("reserved request not refused");
  a_off_refused: assert property (take && !op_req.reserved && !sp_enable |=>
    op_rsp.exc == amx_pkg::exc_disabled)
    else $error("disabled request not refused");
  a_cursor_step: assert property (ok && !cursor_load &&
    op_req.op == amx_pkg::op_shift_in_word |=> cursor == $past(cursor) + 6'h20)
    else $error("cursor did not advance by 32");
  a_read_answer: assert property (rd.req && op_ready && !op_valid && clk_en |=> rd_valid)
    else $error("idle read not answered");
  // A base write in a frozen cycle never lands, so it cannot mark anything
  a_base_flag: assert property (base_wr && clk_en |=> base_unread)
    else $error("base result not marked unread");

  c_mul: cover property (mul);
  c_shift: cover property (ok && op_req.op == amx_pkg::op_shift_in_word);
  c_stall: cover property (rd.req && !op_ready);
endmodule

bind amx_acc amx_acc_monitor #(.MUL_LAT(MUL_LAT)) mon_u (
  .mclk, .rst_b, .clk_en, .sp_enable, .op_valid, .op_req, .rd, .base_wr, .cursor_load,
  .op_ready, .op_rsp, .rd_valid, .base_unread, .cursor
);

`default_nettype wire

// ===== bench/amx_pipe_model.sv
// Pipeline model: presents operations and accumulator reads to the slice.
// Assumes the slice answers within 50 cycles; every wait is bounded.
`default_nettype none

module amx_pipe_model (
  // Clock
  input  wire logic              mclk,
  // Operation request and answer
  output var amx_pkg::amx_req_s  op_req,
  output var logic               op_valid,
  input  wire logic              op_ready,
  input  wire amx_pkg::amx_rsp_s op_rsp,
  // Accumulator read
  output var amx_pkg::amx_rd_s   rd,
  input  wire logic              rd_valid,
  input  wire logic [31:0]       rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    op_valid = 1'b0;
    op_req = '0;
    rd = '0;
  end
  task automatic op(input amx_pkg::amx_op_e o, input logic r, input logic [1:0] i,
                    input logic [31:0] a, input logic [31:0] b, output amx_pkg::amx_exc_e e);
    int n;
    n = 0;
    @(posedge mclk);
    op_valid <= 1'b1;
    op_req <= '{o, r, i, a, b};
    do @(posedge mclk); while (op_ready !== 1'b1 && ++n < 50);
    op_valid <= 1'b0;
    // Released lines carry the complement of the request, never the last value
    op_req <= ~{o, r, i, a, b};
    while (op_rsp.done !== 1'b1 && ++n < 50) @(posedge mclk);
    e = op_rsp.exc;
  endtask
  task automatic read(input logic [1:0] i, input logic u, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    rd <= '{1'b1, i, u};
    do @(posedge mclk); while (rd_valid !== 1'b1 && ++n < 50);
    d = rd_data;
    rd <= '{1'b0, ~i, ~u};
  endtask
endmodule

`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench of the accumulator slice driven through a pipeline model.
// Assumes the slice, its checker and the model are compiled before this file.
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk = 1'b0;
  logic              rst_b = 1'b0;
  logic              clk_en = 1'b1;
  logic              sp_enable = 1'b1;
  logic              base_wr = 1'b0;
  logic              cursor_load = 1'b0;
  logic [63:0]       base_value = '0;
  logic [5:0]        cursor_value = '0;
  logic              op_valid, op_ready, rd_valid, base_unread;
  logic [31:0]       rd_data;
  logic [5:0]        cursor;
  amx_pkg::amx_req_s op_req;
  amx_pkg::amx_rsp_s op_rsp;
  amx_pkg::amx_rd_s  rd;
  amx_pkg::amx_exc_e e;
  logic [63:0]       acc [4];
  int                failures = 0;
  int                tests_run = 0;
  int                cyc = 0;
  always #5 mclk = ~mclk;

  amx_acc #(.MUL_LAT(2)) dut_u (
    .mclk, .rst_b, .clk_en, .sp_enable, .op_valid, .op_req, .op_ready, .op_rsp,
    .rd, .rd_valid, .rd_data, .base_wr, .base_value, .base_unread, .cursor_load,
    .cursor_value, .cursor
  );
  amx_pipe_model pipe_u (
    .mclk, .op_req, .op_valid, .op_ready, .op_rsp, .rd, .rd_valid, .rd_data
  );

  // ==========================================================================
  // Helpers
  task automatic stop_test();
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic go(amx_pkg::amx_op_e o, logic [1:0] i, logic [31:0] a, logic [31:0] b = '0);
    pipe_u.op(o, 1'b0, i, a, b, e);
  endtask
  task automatic rdchk(logic [1:0] i);
    logic [31:0] u, l;
    pipe_u.read(i, 1'b1, u);
    pipe_u.read(i, 1'b0, l);
    `CHK({u, l}, acc[i])
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_moves();
    for (int i = 0; i < 4; i++) begin
      acc[i] = {32'hc0de_0000 | i, 32'h5a00 | i};
      go(amx_pkg::op_move_to_bottom, i[1:0], acc[i][31:0]);
      go(amx_pkg::op_move_to_upper, i[1:0], acc[i][63:32]);
      `CHK(e, amx_pkg::exc_none)
    end
    for (int i = 0; i < 4; i++) rdchk(i[1:0]);
    go(amx_pkg::op_move_to_bottom, 2'h2, 32'h0bad_f00d);
    acc[2][31:0] = 32'h0bad_f00d;
    rdchk(2'h2);
  endtask
  task automatic t_mul();
    logic [31:0] d;
    acc[1] = acc[1] - 64'($signed(32'hffff_fffe)) * 64'($signed(32'h3));
    fork
      go(amx_pkg::op_mul_sub_signed, 2'h1, 32'hffff_fffe, 32'h3);
      begin
        @(posedge mclk);
        pipe_u.read(2'h1, 1'b1, d);
      end
    join
    `CHK(d, acc[1][63:32])
    `CHK(e, amx_pkg::exc_none)
    acc[2] = acc[2] - {32'h0, 32'hffff_ffff} * {32'h0, 32'hffff_ffff} - 64'h1;
    go(amx_pkg::op_mul_sub_unsigned, 2'h2, 32'hffff_ffff, 32'hffff_ffff);
    go(amx_pkg::op_mul_sub_signed, 2'h2, 32'hffff_ffff, 32'hffff_ffff);
    rdchk(2'h1);
    rdchk(2'h2);
    rdchk(2'h3);
  endtask
  task automatic t_shift();
    cursor_value <= 6'h10;
    cursor_load <= 1'b1;
    @(posedge mclk);
    cursor_load <= 1'b0;
    acc[3] = {acc[3][31:0], 32'h1234_5678};
    go(amx_pkg::op_shift_in_word, 2'h3, 32'h1234_5678);
    `CHK(cursor, 6'h10 + amx_pkg::CURSOR_STEP)
    rdchk(2'h3);
  endtask
  task automatic t_exc();
    sp_enable <= 1'b0;
    go(amx_pkg::op_move_to_upper, 2'h3, 32'hdead_beef);
    `CHK(e, amx_pkg::exc_disabled)
    pipe_u.op(amx_pkg::op_mul_sub_signed, 1'b1, 2'h3, 32'h7, 32'h7, e);
    `CHK(e, amx_pkg::exc_reserved)
    sp_enable <= 1'b1;
    pipe_u.op(amx_pkg::op_shift_in_word, 1'b1, 2'h3, 32'h7, 32'h7, e);
    `CHK(e, amx_pkg::exc_reserved)
    `CHK(cursor, 6'h30)
    rdchk(2'h3);
  endtask
  task automatic t_base();
    // A base write offered while the clock enable is low must not land
    clk_en <= 1'b0;
    base_value <= 64'hfeed_0000_0000_0001;
    base_wr <= 1'b1;
    @(posedge mclk);
    clk_en <= 1'b1;
    base_wr <= 1'b0;
    @(posedge mclk);
    `CHK(base_unread, 1'b0)
    base_value <= 64'h0123_4567_89ab_cdef;
    base_wr <= 1'b1;
    @(posedge mclk);
    base_wr <= 1'b0;
    acc[0] = 64'h0123_4567_89ab_cdef;
    @(posedge mclk);
    `CHK(base_unread, 1'b1)
    rdchk(2'h0);
    `CHK(base_unread, 1'b0)
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_moves();
    t_mul();
    t_shift();
    t_exc();
    t_base();
    stop_test();
  end
  // Whole run needs well under 1000 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      failures = failures + 1;
      stop_test();
    end
  end
endmodule

`default_nettype wire
